// ### aed_decoder.sv
// Top: instruction classification and effective-address generation
// What this block does
// RULE_01: Classify the 61 instructions into five types
// RULE_02: Ten addressing modes each yield effective address; inherent and relative here give 0 with ea_used low
// RULE_03: Inherent uses opcode only, no operand fetch
// RULE_04: Immediate address is PC plus one, advance two
// RULE_05: Direct: high byte zero, low operand, advance two
// RULE_06: Direct covers the lowest 256 addresses
// RULE_07: Extended: high then low byte, advance three
// RULE_08: Indexed no offset: zero-extended index, advance one
// RULE_09: Jump and call use address, no register
// RULE_10: Read-modify-write writes back except test instruction
// RULE_11: Branches two bytes, taken only when condition holds
// RULE_12: Bit set or clear anywhere in page zero
// RULE_13: Bit test copies bit into carry, branches
// RULE_14: Offset indexed adds unsigned offset to index
// RULE_15: Branch target: next address plus signed displacement
`timescale 1ns/1ps
`default_nettype none
module aed_decoder
    import aed_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction bytes as fetched at PC, PC+1, PC+2
    input wire logic instr_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] byte1,
    input wire logic [7:0] byte2,
    input wire logic [15:0] pc,
    input wire logic [7:0] index_reg,
    // Branch condition and tested memory byte
    input wire logic cond_true,
    input wire logic [7:0] bit_operand,
    // Decoded results
    output logic out_valid,
    output logic [3:0] instr_class,
    output logic [3:0] addr_mode,
    output logic [15:0] effective_address,
    output logic ea_used,
    output logic [15:0] next_pc,
    output logic reg_operand,
    output logic writes_back,
    output logic bit_value,
    output logic bit_new_value,
    output logic carry_load,
    output logic branch_taken,
    output logic illegal
);
    aed_ops_if ops();
    assign ops.opcode = opcode;

    aed_classify u_classify (
        .ops(ops)
    );

    wire [3:0] mode = ops.mode;
    wire [15:0] seq_pc = pc + ops.length;
    wire [15:0] ix16 = {AED_ZERO_PAGE_HIGH, index_reg};
    wire [15:0] direct_ea = {AED_ZERO_PAGE_HIGH, byte1}; // RULE_05 RULE_06
    wire [15:0] ext_ea = {byte1, byte2}; // RULE_07
    wire [15:0] ix1_ea = ix16 + {AED_ZERO_PAGE_HIGH, byte1}; // RULE_14
    wire [15:0] ix2_ea = ix16 + {byte1, byte2}; // RULE_14
    wire [15:0] imm_ea = pc + AED_LEN_ONE; // RULE_04
    wire [2:0] bit_sel = opcode[3:1];
    wire tested_bit = bit_operand[bit_sel]; // RULE_13
    wire [7:0] rel_disp = (mode == 4'(AED_AM_BIT_TEST_BRANCH)) ? byte2 : byte1;
    wire [15:0] rel_target = seq_pc + {{8{rel_disp[7]}}, rel_disp}; // RULE_15
    // Test-branch sense: even opcode branches on set, odd on clear
    wire btb_cond = opcode[0] ? !tested_bit : tested_bit;
    wire take = (mode == 4'(AED_AM_RELATIVE)) ? cond_true :
                (mode == 4'(AED_AM_BIT_TEST_BRANCH)) ? btb_cond : 1'b0; // RULE_11 RULE_13
    wire is_jump = (ops.cls == 4'(AED_CLS_REG_MEM)) && !ops.reg_operand;

    logic [15:0] ea_sel;
    logic used_sel;
    always_comb begin
        ea_sel = 16'h0000;
        used_sel = 1'b1;
        case (mode)
            4'(AED_AM_INHERENT): used_sel = 1'b0; // RULE_03
            4'(AED_AM_IMMEDIATE): ea_sel = imm_ea; // RULE_04
            4'(AED_AM_DIRECT), 4'(AED_AM_BIT_SET_CLR), 4'(AED_AM_BIT_TEST_BRANCH): ea_sel = direct_ea; // RULE_12
            4'(AED_AM_EXTENDED): ea_sel = ext_ea; // RULE_07
            4'(AED_AM_IX0): ea_sel = ix16; // RULE_08
            4'(AED_AM_IX1): ea_sel = ix1_ea;
            4'(AED_AM_IX2): ea_sel = ix2_ea;
            4'(AED_AM_RELATIVE): used_sel = 1'b0;
            default: used_sel = 1'b0;
        endcase
    end

    // Jump and call leave through the effective address
    wire [15:0] pc_sel = is_jump ? ea_sel : take ? rel_target : seq_pc; // RULE_09
    // Set on even opcode, clear on odd, in page zero only
    wire new_bit = !opcode[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            instr_class <= 4'h0;
            addr_mode <= 4'h0;
            effective_address <= 16'h0000;
            ea_used <= 1'b0;
            next_pc <= 16'h0000;
            reg_operand <= 1'b0;
            writes_back <= 1'b0;
            bit_value <= 1'b0;
            bit_new_value <= 1'b0;
            carry_load <= 1'b0;
            branch_taken <= 1'b0;
            illegal <= 1'b0;
        end else begin
            out_valid <= instr_valid;
            instr_class <= ops.cls;
            addr_mode <= mode;
            effective_address <= ea_sel;
            ea_used <= used_sel;
            next_pc <= pc_sel;
            reg_operand <= ops.reg_operand; // RULE_09
            writes_back <= ops.writes_back || (mode == 4'(AED_AM_BIT_SET_CLR)); // RULE_10 RULE_12
            bit_value <= tested_bit;
            bit_new_value <= new_bit; // RULE_12
            carry_load <= (mode == 4'(AED_AM_BIT_TEST_BRANCH)); // RULE_13
            branch_taken <= take;
            illegal <= !ops.legal;
        end
    end
endmodule
`default_nettype wire

// ### aed_pkg.sv
// Package: opcode classes, addressing modes and decoder constants
package aed_pkg;
    localparam int AED_BASE_INSTR_COUNT = 61;
    localparam logic [7:0] AED_ZERO_PAGE_HIGH = 8'h00;
    localparam int AED_EXT_ROM_DIRECT_BYTES = 128;
    localparam logic [15:0] AED_PAGE_LIMIT = 16'h0100;
    localparam logic [15:0] AED_LEN_ONE = 16'h0001;
    localparam logic [15:0] AED_LEN_TWO = 16'h0002;
    localparam logic [15:0] AED_LEN_THREE = 16'h0003;
    localparam logic [7:0] AED_OP_JUMP_EXT = 8'hCC;
    localparam logic [7:0] AED_OP_CALL_EXT = 8'hCD;
    localparam logic [3:0] AED_LOW_JUMP = 4'hC;
    localparam logic [3:0] AED_LOW_CALL = 4'hD;
    localparam logic [3:0] AED_LOW_TEST = 4'hD;
    localparam logic [3:0] AED_LOW_STORE_A = 4'h7;
    localparam logic [3:0] AED_LOW_STORE_X = 4'hF;

    // Five classes need three bits; kept at the port width of four
    typedef enum logic [3:0] {
        AED_CLS_REG_MEM,
        AED_CLS_RMW,
        AED_CLS_BRANCH,
        AED_CLS_BIT,
        AED_CLS_CONTROL
    } aed_class_e;

    typedef enum logic [3:0] {
        AED_AM_INHERENT,
        AED_AM_IMMEDIATE,
        AED_AM_DIRECT,
        AED_AM_EXTENDED,
        AED_AM_IX0,
        AED_AM_IX1,
        AED_AM_IX2,
        AED_AM_RELATIVE,
        AED_AM_BIT_SET_CLR,
        AED_AM_BIT_TEST_BRANCH
    } aed_mode_e;
endpackage

// ### aed_ops_if.sv
// Interface: opcode classification between decoder and address former
`timescale 1ns/1ps
`default_nettype none
interface aed_ops_if;
    import aed_pkg::*;
    logic [7:0] opcode;
    logic [3:0] cls;
    logic [3:0] mode;
    logic [15:0] length;
    logic reg_operand;
    logic writes_back;
    logic legal;
    modport decoder (input opcode, output cls, output mode, output length, output reg_operand,
        output writes_back, output legal);
    modport user (output opcode, input cls, input mode, input length, input reg_operand,
        input writes_back, input legal);
endinterface
`default_nettype wire

// ### aed_classify.sv
// Opcode classifier: class, addressing mode and length
`timescale 1ns/1ps
`default_nettype none
module aed_classify
    import aed_pkg::*;
(
    aed_ops_if.decoder ops
);
    wire [3:0] hi = ops.opcode[7:4];
    wire [3:0] lo = ops.opcode[3:0];
    wire is_bit = (hi == 4'h0) || (hi == 4'h1);
    wire is_branch = (hi == 4'h2);
    wire is_rmw = (hi >= 4'h3) && (hi <= 4'h7);
    wire is_ctrl = (hi == 4'h8) || (hi == 4'h9);
    wire is_regmem = (hi >= 4'hA);
    wire rmw_test = is_rmw && (lo == AED_LOW_TEST);
    wire [3:0] rmw_mode = (hi == 4'h3) ? 4'(AED_AM_DIRECT) :
                          (hi == 4'h6) ? 4'(AED_AM_IX1) :
                          (hi == 4'h7) ? 4'(AED_AM_IX0) : 4'(AED_AM_INHERENT); // RULE_03
    wire [3:0] rm_mode = (hi == 4'hA) ? 4'(AED_AM_IMMEDIATE) :
                         (hi == 4'hB) ? 4'(AED_AM_DIRECT) :
                         (hi == 4'hC) ? 4'(AED_AM_EXTENDED) :
                         (hi == 4'hD) ? 4'(AED_AM_IX2) :
                         (hi == 4'hE) ? 4'(AED_AM_IX1) : 4'(AED_AM_IX0);
    wire no_reg = (lo == AED_LOW_JUMP) || (lo == AED_LOW_CALL);
    // Store forms and jump have no immediate form
    wire rm_hole = (hi == 4'hA) && ((lo == AED_LOW_STORE_A) || (lo == AED_LOW_JUMP) || (lo == AED_LOW_STORE_X));

    function automatic logic [15:0] mode_len(input logic [3:0] m);
        case (m)
            4'(AED_AM_INHERENT), 4'(AED_AM_IX0): mode_len = AED_LEN_ONE; // RULE_08
            4'(AED_AM_EXTENDED), 4'(AED_AM_IX2), 4'(AED_AM_BIT_TEST_BRANCH): mode_len = AED_LEN_THREE; // RULE_07
            default: mode_len = AED_LEN_TWO; // RULE_04 RULE_05 RULE_11
        endcase
    endfunction

    assign ops.cls = is_bit ? 4'(AED_CLS_BIT) : is_branch ? 4'(AED_CLS_BRANCH) :
                     is_rmw ? 4'(AED_CLS_RMW) : is_ctrl ? 4'(AED_CLS_CONTROL) : 4'(AED_CLS_REG_MEM); // RULE_01
    assign ops.mode = (hi == 4'h0) ? 4'(AED_AM_BIT_TEST_BRANCH) :
                      (hi == 4'h1) ? 4'(AED_AM_BIT_SET_CLR) :
                      is_branch ? 4'(AED_AM_RELATIVE) :
                      is_rmw ? rmw_mode :
                      is_ctrl ? 4'(AED_AM_INHERENT) : rm_mode; // RULE_02
    assign ops.length = mode_len(ops.mode);
    assign ops.reg_operand = is_regmem && !no_reg; // RULE_09
    assign ops.writes_back = is_rmw && !rmw_test; // RULE_10
    assign ops.legal = !rm_hole;
endmodule
`default_nettype wire

// ### aed_decoder_chk.sv
// Checker: address, length and write-back relations of the decoder
`timescale 1ns/1ps
`default_nettype none
module aed_decoder_chk
    import aed_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction inputs
    input wire logic instr_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] byte1,
    input wire logic [7:0] byte2,
    input wire logic [15:0] pc,
    input wire logic [7:0] index_reg,
    input wire logic cond_true,
    // Decoded results
    input wire logic [15:0] effective_address,
    input wire logic ea_used,
    input wire logic [15:0] next_pc,
    input wire logic reg_operand,
    input wire logic writes_back
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_imm;
        instr_valid && opcode == 8'hA6 |=> effective_address == $past(pc) + 16'h0001 && next_pc == $past(pc) + 16'h0002;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate address or advance wrong");
    property p_dir;
        instr_valid && opcode[7:4] == 4'hB |=> effective_address == {8'h00, $past(byte1)};
    endproperty
    a_dir: assert property (p_dir) else $error("direct address wrong");
    property p_ext;
        instr_valid && opcode == 8'hC6 |=> effective_address == {$past(byte1), $past(byte2)} && next_pc == $past(pc) + 16'h0003;
    endproperty
    a_ext: assert property (p_ext) else $error("extended address or advance wrong");
    property p_ix0;
        instr_valid && opcode == 8'hF6 |=> effective_address == {8'h00, $past(index_reg)} && next_pc == $past(pc) + 16'h0001;
    endproperty
    a_ix0: assert property (p_ix0) else $error("indexed address wrong");
    property p_inh;
        instr_valid && opcode[7:4] == 4'h4 |=> !ea_used && next_pc == $past(pc) + 16'h0001;
    endproperty
    a_inh: assert property (p_inh) else $error("inherent fetched an operand");
    property p_jmp;
        instr_valid && opcode[7:4] > 4'hA && opcode[3:1] == 3'h6 |=> !reg_operand && next_pc == effective_address;
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump or call wrong");
    property p_tst;
        instr_valid && opcode[7:1] == 7'h1E |=> writes_back == ($past(opcode[0]) == 1'b0);
    endproperty
    a_tst: assert property (p_tst) else $error("write-back wrong");
    property p_br;
        instr_valid && opcode[7:4] == 4'h2 |=> next_pc == $past(pc) + 16'h0002 + ($past(cond_true) ? {{8{$past(byte1[7])}}, $past(byte1)} : 16'h0000);
    endproperty
    a_br: assert property (p_br) else $error("branch target wrong");
    property p_ix1;
        instr_valid && opcode == 8'hE6 |=> effective_address == {8'h00, $past(index_reg)} + {8'h00, $past(byte1)};
    endproperty
    a_ix1: assert property (p_ix1) else $error("offset indexed address wrong");
    c_ext: cover property (instr_valid && opcode == 8'hC6);
    c_br: cover property (instr_valid && opcode[7:4] == 4'h2 && cond_true);
    c_tst: cover property (instr_valid && opcode == 8'h3D);
endmodule
bind aed_decoder aed_decoder_chk i_chk (.*);
`default_nettype wire

// ### aed_mem.sv
// Partner: program and data memory behind the address bus
`timescale 1ns/1ps
`default_nettype none
module aed_mem (
    // Fetch address
    input wire logic [15:0] pc,
    // Bytes at PC, PC+1, PC+2 and at the direct address
    output logic [7:0] opcode,
    output logic [7:0] byte1,
    output logic [7:0] byte2,
    output logic [7:0] bit_operand
);
    logic [7:0] mem [65536];
    // Patterned fill, so stale reads look like zeros only where the low address byte is 5A
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'h5A ^ i[7:0];
    assign opcode = mem[pc];
    assign byte1 = mem[pc + 16'h0001];
    assign byte2 = mem[pc + 16'h0002];
    assign bit_operand = mem[{8'h00, byte1}];
endmodule
`default_nettype wire

// ### aed_decoder_tb_top.sv
// Testbench: directed decode scenarios against the memory model
`timescale 1ns/1ps
`default_nettype none
module aed_decoder_tb_top;
    import aed_pkg::*;
    logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, cond_true = 1'b0;
    logic [15:0] pc = 16'h0000;
    logic [7:0] index_reg = 8'h00;
    logic [7:0] opcode, byte1, byte2, bit_operand;
    logic out_valid, ea_used, reg_operand, writes_back, bit_value, bit_new_value, carry_load, branch_taken, illegal;
    logic [3:0] instr_class, addr_mode;
    logic [15:0] effective_address, next_pc;
    int n_fail = 0, n_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    aed_mem i_mem (.pc(pc), .opcode(opcode), .byte1(byte1), .byte2(byte2), .bit_operand(bit_operand));
    aed_decoder i_dut (.*);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task issue(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2, input logic [15:0] p,
        input logic [7:0] x, input logic c);
        i_mem.mem[p] = o;
        i_mem.mem[p + 16'h0001] = b1;
        i_mem.mem[p + 16'h0002] = b2;
        @(posedge clk);
        pc <= p;
        index_reg <= x;
        cond_true <= c;
        instr_valid <= 1'b1;
        @(posedge clk);
        #1;
        chk(out_valid, 16'h0001);
    endtask
    task t_modes;
        issue(8'hC6, 8'h12, 8'h34, 16'h0100, 8'h00, 1'b0);
        chk(effective_address, 16'h1234);
        chk(next_pc, 16'h0103);
        chk(addr_mode, AED_AM_EXTENDED);
        chk(reg_operand, 16'h0001);
        issue(8'hA6, 8'h77, 8'h00, 16'hFFFE, 8'h00, 1'b0);
        chk(effective_address, 16'hFFFF);
        chk(next_pc, 16'h0000);
        issue(8'hB6, 8'h80, 8'h00, 16'h2000, 8'h00, 1'b0);
        chk(effective_address, 16'h0080);
        chk(next_pc, 16'h2002);
        issue(8'hF6, 8'h00, 8'h00, 16'h0300, 8'hFF, 1'b0);
        chk(effective_address, 16'h00FF);
        chk(next_pc, 16'h0301);
        issue(8'h4C, 8'h00, 8'h00, 16'h0400, 8'h00, 1'b0);
        chk(ea_used, 16'h0000);
        chk(next_pc, 16'h0401);
        issue(8'hE6, 8'hF0, 8'h00, 16'h0200, 8'h20, 1'b0);
        chk(effective_address, 16'h0110);
        chk(next_pc, 16'h0202);
        issue(8'hD6, 8'h12, 8'h34, 16'h0210, 8'h80, 1'b0);
        chk(effective_address, 16'h12B4);
        chk(next_pc, 16'h0213);
    endtask
    task t_classes;
        for (int k = 0; k < 2; k++) begin
            issue(8'hCC + 8'(k), 8'h45, 8'h67, 16'h0600, 8'h00, 1'b0);
            chk(reg_operand, 16'h0000);
            chk(next_pc, 16'h4567);
            issue(8'h3C + 8'(k), 8'h20, 8'h00, 16'h0700, 8'h00, 1'b0);
            chk(writes_back, 16'(1 - k));
            chk(instr_class, AED_CLS_RMW);
        end
        issue(8'hA7, 8'h00, 8'h00, 16'h0800, 8'h00, 1'b0);
        chk(illegal, 16'h0001);
    endtask
    task t_branch;
        issue(8'h20, 8'hFE, 8'h00, 16'h0100, 8'h00, 1'b1);
        chk(next_pc, 16'h0100);
        chk(branch_taken, 16'h0001);
        issue(8'h20, 8'h7F, 8'h00, 16'h0900, 8'h00, 1'b0);
        chk(next_pc, 16'h0902);
        chk(branch_taken, 16'h0000);
    endtask
    task t_bits;
        issue(8'h10, 8'h40, 8'h00, 16'h0A00, 8'h00, 1'b0);
        chk(writes_back, 16'h0001);
        chk(bit_new_value, 16'h0001);
        i_mem.mem[16'h0040] = 8'h00;
        issue(8'h01, 8'h40, 8'h10, 16'h0500, 8'h00, 1'b0);
        chk(carry_load, 16'h0001);
        chk(bit_value, 16'h0000);
        chk(next_pc, 16'h0513);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Runaway guard well above the 44 or so cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_modes();
        t_classes();
        t_branch();
        t_bits();
        give_verdict();
    end
endmodule
`default_nettype wire
